// ===== design/headphone_supply_pump_control.sv
// control logic of the dual-mode headphone supply pump
// assumes an avalon-mm master on i_clk and audio levels synchronous to i_clk
//
// The Avalon-MM slave port is this design's own decision.
`default_nettype none
module headphone_supply_pump_control
    import pump_ctrl_pkg::*;
#(
    parameter int DIV_MAX = 16 // largest supported divide ratio
) (
    input wire logic i_clk, // 20 mhz clock
    input wire logic i_reset_n, // async reset, active low
    input wire logic [ADDR_W-1:0] i_address, // byte address
    input wire logic i_read, // read request
    input wire logic i_write, // write request
    input wire logic [31:0] i_writedata, // write data
    input wire logic [3:0] i_byteenable, // byte lanes
    output logic [31:0] o_readdata, // read data
    output logic o_waitrequest, // stall
    input wire logic i_mclk_present, // master clock present (pin)
    input wire logic i_loop_locked, // loop output valid
    input wire logic [LEVEL_W-1:0] i_first_level, // first port dac level
    input wire logic [LEVEL_W-1:0] i_second_level, // second port dac level
    output var pump_out_t o_pump // pump drive bundle
);
    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (DIV_MAX < 2 || DIV_MAX > 16) begin : g_chk
        $error("DIV_MAX out of range");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        ctrl_t ctrl;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] mclk_sync;
        logic [DIV_W-1:0] div_cnt;
        logic pump_tick;
        logic track_live;
        logic [1:0] source_live;
        point_t point;
        rail_t rail;
    } state_t;

    state_t s;
    state_t next_s;
    logic word_ok;
    logic [7:0] index;
    logic [31:0] wmask;
    logic [31:0] ctrl_word;
    logic clock_ok;
    logic [LEVEL_W-1:0] level;
    logic [VOL_W-1:0] vol_max;
    point_t want;

    assign index = i_address[ADDR_W-1:2];
    assign word_ok = (i_address[1:0] == 2'h0);
    assign wmask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                    {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        ctrl_word = 32'h0;
        next_s.ack = 1'b0;
        // bus slave: one wait cycle, then ack
        if ((i_read || i_write) && !s.ack) begin
            next_s.ack = 1'b1;
            next_s.rdata = 32'h0;
            if (word_ok) begin
                case (index)
                    ENABLE_CTRL_IDX: ctrl_word[ENABLE_BIT] = s.ctrl.enable;
                    DISCHARGE_CTRL_IDX: ctrl_word[DISCHARGE_BIT] = s.ctrl.discharge;
                    TRACKING_CTRL_IDX: begin
                        ctrl_word[SOURCE_LSB +: 2] = s.ctrl.source;
                        ctrl_word[TRACK_BIT] = s.ctrl.track;
                    end
                    VOLUME_CTRL_IDX: begin
                        ctrl_word[LEFT_VOL_LSB +: VOL_W] = s.ctrl.left_vol;
                        ctrl_word[RIGHT_VOL_LSB +: VOL_W] = s.ctrl.right_vol;
                    end
                    PUMP_STATUS_IDX: ctrl_word[8:0] = {s.source_live, s.track_live,
                                                       s.point, s.rail};
                    CLOCK_CTRL_IDX: begin
                        ctrl_word[CLKSRC_BIT] = s.ctrl.clk_source;
                        ctrl_word[FREERUN_BIT] = s.ctrl.free_run;
                        ctrl_word[DIV_LSB +: DIV_W] = s.ctrl.div;
                    end
                    default: ctrl_word = 32'h0;
                endcase
                next_s.rdata = ctrl_word;
            end
        end

        // a write lands only at the edge where waitrequest is seen low
        if (i_write && s.ack && word_ok) begin
            case (index)
                ENABLE_CTRL_IDX:
                    if (wmask[ENABLE_BIT]) next_s.ctrl.enable = i_writedata[ENABLE_BIT];
                DISCHARGE_CTRL_IDX:
                    if (wmask[DISCHARGE_BIT]) begin
                        next_s.ctrl.discharge = i_writedata[DISCHARGE_BIT];
                    end
                TRACKING_CTRL_IDX: begin
                    if (wmask[SOURCE_LSB]) begin
                        next_s.ctrl.source = i_writedata[SOURCE_LSB +: 2];
                    end
                    if (wmask[TRACK_BIT]) next_s.ctrl.track = i_writedata[TRACK_BIT];
                end
                VOLUME_CTRL_IDX: begin
                    if (wmask[LEFT_VOL_LSB]) begin
                        next_s.ctrl.left_vol = i_writedata[LEFT_VOL_LSB +: VOL_W];
                    end
                    if (wmask[RIGHT_VOL_LSB]) begin
                        next_s.ctrl.right_vol = i_writedata[RIGHT_VOL_LSB +: VOL_W];
                    end
                end
                CLOCK_CTRL_IDX:
                    if (wmask[0]) begin
                        next_s.ctrl.clk_source = i_writedata[CLKSRC_BIT];
                        next_s.ctrl.free_run = i_writedata[FREERUN_BIT];
                        next_s.ctrl.div = i_writedata[DIV_LSB +: DIV_W];
                    end
                default: next_s.ctrl = s.ctrl;
            endcase
        end

        // master clock presence passes two flops
        next_s.mclk_sync = {s.mclk_sync[0], i_mclk_present};

        // core clock usable: master clock, or loop locked or free running
        clock_ok = s.ctrl.clk_source ? (i_loop_locked || s.ctrl.free_run)
                                     : s.mclk_sync[1];

        // pump clock enable divided from the core clock
        next_s.pump_tick = 1'b0;
        if (s.ctrl.enable && clock_ok) begin
            if (s.div_cnt >= s.ctrl.div) begin
                next_s.div_cnt = '0;
                next_s.pump_tick = 1'b1;
            end else begin
                next_s.div_cnt = s.div_cnt + 1'b1;
            end
        end else begin
            next_s.div_cnt = '0;
        end

        // mode and source latched only on pump ticks
        if (s.pump_tick) begin
            next_s.track_live = s.ctrl.track;
            next_s.source_live = s.ctrl.source;
        end

        // operating point from volumes or from the tracked level
        level = (s.source_live == SRC_SECOND) ? i_second_level : i_first_level;
        if (s.source_live != SRC_FIRST && s.source_live != SRC_SECOND) begin
            level = i_first_level;
        end
        vol_max = (s.ctrl.left_vol > s.ctrl.right_vol) ? s.ctrl.left_vol
                                                        : s.ctrl.right_vol;
        if (s.track_live) begin
            want = (level >= LVL_HIGH_TH) ? PT_HIGH :
                   (level >= LVL_MID_TH) ? PT_MID : PT_LOW;
        end else begin
            want = (vol_max >= VOL_HIGH_TH) ? PT_HIGH :
                   (vol_max >= VOL_MID_TH) ? PT_MID : PT_LOW;
        end
        if (s.pump_tick) begin
            next_s.point = want;
        end

        // rail state
        if (s.ctrl.enable && clock_ok) begin
            next_s.rail = RAIL_RUN;
        end else begin
            next_s.rail = s.ctrl.discharge ? RAIL_DISCH : RAIL_FLOAT;
            next_s.point = PT_LOW;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s.ctrl.enable <= ENABLE_RST;
            s.ctrl.discharge <= DISCHARGE_RST;
            s.ctrl.track <= TRACK_RST;
            s.ctrl.source <= SOURCE_RST;
            s.ctrl.left_vol <= VOL_RST;
            s.ctrl.right_vol <= VOL_RST;
            s.ctrl.clk_source <= 1'b0;
            s.ctrl.free_run <= 1'b0;
            s.ctrl.div <= DIV_RST;
            s.ack <= 1'b0;
            s.rdata <= 32'h0;
            s.mclk_sync <= 2'h0;
            s.div_cnt <= '0;
            s.pump_tick <= 1'b0;
            s.track_live <= TRACK_RST;
            s.source_live <= SOURCE_RST;
            s.point <= PT_LOW;
            s.rail <= RAIL_DISCH;
        end else begin
            s <= next_s;
        end
    end

    // outputs
    assign o_waitrequest = (i_read || i_write) && !s.ack;
    assign o_readdata = s.rdata;
    assign o_pump = '{pump_clk_en: s.pump_tick, point: s.point, rail: s.rail};

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence write_enable_s;
        i_write && !o_waitrequest && word_ok && index == ENABLE_CTRL_IDX &&
        i_byteenable[1] && i_writedata[ENABLE_BIT];
    endsequence

    run_needs_enable_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_pump.rail == RAIL_RUN |-> $past(s.ctrl.enable))
        else $error("pump running while disabled");

    disabled_discharge_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !$past(s.ctrl.enable) |-> o_pump.rail == ($past(s.ctrl.discharge) ? RAIL_DISCH
                                                                            : RAIL_FLOAT))
        else $error("wrong disabled rail state");

    tick_only_enabled_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_pump.pump_clk_en |-> $past(s.ctrl.enable) &&
        (!$past(o_pump.pump_clk_en) || $past(s.ctrl.div) == '0))
        else $error("pump tick while disabled");

    enable_write_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        write_enable_s |=> s.ctrl.enable)
        else $error("enable write lost");

    mode_on_tick_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $changed(s.track_live) |-> $past(s.pump_tick))
        else $error("mode changed off tick");

    source_on_tick_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $changed(s.source_live) |-> $past(s.pump_tick))
        else $error("source changed off tick");

    point_stable_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        ($changed(o_pump.point) && o_pump.rail == RAIL_RUN) |-> $past(s.pump_tick))
        else $error("point glitch");

    volume_point_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (s.pump_tick && !s.track_live && s.ctrl.enable && clock_ok && vol_max < VOL_MID_TH)
        |=> o_pump.point == PT_LOW)
        else $error("volume point wrong");

    bus_answer_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_read || i_write) && o_waitrequest |=> !o_waitrequest)
        else $error("bus answer late");

    sequence bus_done_s;
        (i_read || i_write) && !o_waitrequest;
    endsequence

    sequence write_disable_s;
        i_write && !o_waitrequest && word_ok && index == ENABLE_CTRL_IDX &&
        i_byteenable[1] && !i_writedata[ENABLE_BIT];
    endsequence

    sequence write_float_s;
        i_write && !o_waitrequest && word_ok && index == DISCHARGE_CTRL_IDX &&
        i_byteenable[1] && !i_writedata[DISCHARGE_BIT];
    endsequence

    sequence read_discharge_s;
        i_read && !o_waitrequest && word_ok && index == DISCHARGE_CTRL_IDX;
    endsequence

    sequence read_enable_s;
        i_read && !o_waitrequest && word_ok && index == ENABLE_CTRL_IDX;
    endsequence

    one_wait_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        bus_done_s |-> $past(o_waitrequest))
        else $error("bus answer without wait");

    read_enable_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        read_enable_s |-> o_readdata[ENABLE_BIT] == s.ctrl.enable)
        else $error("enable readback wrong");

    read_discharge_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        read_discharge_s |-> o_readdata[DISCHARGE_BIT] == s.ctrl.discharge)
        else $error("discharge readback wrong");

    disable_write_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        write_disable_s |=> !s.ctrl.enable)
        else $error("disable write lost");

    float_write_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        write_float_s |=> !s.ctrl.discharge)
        else $error("discharge clear lost");

    rail_run_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s.ctrl.enable && clock_ok |=> o_pump.rail == RAIL_RUN)
        else $error("pump not running while enabled");

    clock_gone_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !clock_ok |=> o_pump.rail != RAIL_RUN && !o_pump.pump_clk_en)
        else $error("pump running without clock");

    volume_high_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (s.pump_tick && !s.track_live && s.ctrl.enable && clock_ok && vol_max >= VOL_HIGH_TH)
        |=> o_pump.point == PT_HIGH)
        else $error("volume point not high");

    level_high_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (s.pump_tick && s.track_live && s.ctrl.enable && clock_ok && level >= LVL_HIGH_TH)
        |=> o_pump.point == PT_HIGH)
        else $error("level point not high");

    onehot_out_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $onehot(o_pump.point) && $onehot(o_pump.rail))
        else $error("pump state not one-hot");

    tick_count_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_pump.pump_clk_en |-> s.div_cnt == '0)
        else $error("tick off divider wrap");
endmodule : headphone_supply_pump_control
`default_nettype wire

// ===== design/pump_ctrl_pkg.sv
// package for the headphone supply pump control block
// assumes a 32-bit avalon-mm slave with word addressing by byte address
`default_nettype none
package pump_ctrl_pkg;
    // ----------------------------------------------------------------
    // register map (printed offsets are indices, byte address is 4x)
    // ----------------------------------------------------------------
    localparam logic [7:0] ENABLE_CTRL_IDX = 8'h4c;
    localparam logic [7:0] DISCHARGE_CTRL_IDX = 8'h4d;
    localparam logic [7:0] TRACKING_CTRL_IDX = 8'h51;
    localparam logic [7:0] VOLUME_CTRL_IDX = 8'h60;
    localparam logic [7:0] PUMP_STATUS_IDX = 8'h61;
    localparam logic [7:0] CLOCK_CTRL_IDX = 8'h62;
    localparam int ADDR_W = 10;
    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int ENABLE_BIT = 15;
    localparam int DISCHARGE_BIT = 15;
    localparam int SOURCE_LSB = 8;
    localparam int TRACK_BIT = 0;
    localparam int LEFT_VOL_LSB = 0;
    localparam int RIGHT_VOL_LSB = 8;
    localparam int VOL_W = 6;
    localparam int LEVEL_W = 16;
    localparam int CLKSRC_BIT = 0;
    localparam int FREERUN_BIT = 1;
    localparam int DIV_LSB = 4;
    localparam int DIV_W = 4;
    localparam logic ENABLE_RST = 1'b0;
    localparam logic DISCHARGE_RST = 1'b1;
    localparam logic TRACK_RST = 1'b0;
    localparam logic [1:0] SOURCE_RST = 2'h0;
    localparam logic [1:0] SRC_FIRST = 2'h0;
    localparam logic [1:0] SRC_SECOND = 2'h2;
    localparam logic [VOL_W-1:0] VOL_RST = 6'h39;
    localparam logic [DIV_W-1:0] DIV_RST = 4'h9;
    // ----------------------------------------------------------------
    // operating point thresholds
    // ----------------------------------------------------------------
    localparam logic [VOL_W-1:0] VOL_MID_TH = 6'h2d;
    localparam logic [VOL_W-1:0] VOL_HIGH_TH = 6'h37;
    localparam logic [LEVEL_W-1:0] LVL_MID_TH = 16'h1000;
    localparam logic [LEVEL_W-1:0] LVL_HIGH_TH = 16'h4000;
    localparam int CLOCK_HZ = 20000000;
    localparam int RDATA_W = 32;

    // operating point of the rails: low, mid, high (one-hot)
    typedef enum logic [2:0] {
        PT_LOW = 3'b001,
        PT_MID = 3'b010,
        PT_HIGH = 3'b100
    } point_t;

    // pump output state
    typedef enum logic [2:0] {
        RAIL_FLOAT = 3'b001,
        RAIL_DISCH = 3'b010,
        RAIL_RUN = 3'b100
    } rail_t;

    // software controls
    typedef struct packed {
        logic enable;
        logic discharge;
        logic track;
        logic [1:0] source;
        logic [VOL_W-1:0] left_vol;
        logic [VOL_W-1:0] right_vol;
        logic clk_source;
        logic free_run;
        logic [DIV_W-1:0] div;
    } ctrl_t;

    // pump output bundle
    typedef struct packed {
        logic pump_clk_en;
        point_t point;
        rail_t rail;
    } pump_out_t;
endpackage : pump_ctrl_pkg
`default_nettype wire

// ===== dv/rail_load_model.sv
// far-side model: the digital audio path that feeds the headphone drivers
// assumes it shares the block clock and sees the pump drive bundle
`default_nettype none
module rail_load_model
    import pump_ctrl_pkg::*;
(
    input wire logic i_clk, // block clock
    input wire logic [LEVEL_W-1:0] i_play_first, // level played on first port
    input wire logic [LEVEL_W-1:0] i_play_second, // level played on second port
    input wire pump_out_t i_pump, // pump drive bundle
    output logic [LEVEL_W-1:0] o_first_level, // first port dac level
    output logic [LEVEL_W-1:0] o_second_level, // second port dac level
    output int o_ticks // pump clock pulses seen
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_first_level = '0;
        o_second_level = '0;
        o_ticks = 0;
    end
    // both ports can play at once; levels move just after the edge
    always @(posedge i_clk) begin
        o_first_level <= i_play_first;
        o_second_level <= i_play_second;
        if (i_pump.pump_clk_en === 1'b1) o_ticks <= o_ticks + 1;
    end
endmodule : rail_load_model
`default_nettype wire

// ===== dv/headphone_supply_pump_control_tb.sv
// self-checking bench for the headphone supply pump control block
// assumes the avalon-mm answer timing and register map of the design package
`default_nettype none
module headphone_supply_pump_control_tb;
    import pump_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_reset_n = 0, i_read = 0, i_write = 0;
    logic [ADDR_W-1:0] i_address = '0;
    logic [31:0] i_writedata = '0, o_readdata, rd;
    logic o_waitrequest, i_mclk_present = 1, i_loop_locked = 0;
    logic [LEVEL_W-1:0] play1 = '0, play2 = '0, lvl1, lvl2;
    pump_out_t o_pump;
    int ticks, num_errors = 0, checked = 0;
    int en = 0, dis = 1, trk = 0, src = 0, lv = 'h39, rv = 'h39, cs = 0, fr = 0;
    int vols[4] = '{'h2c, 'h2d, 'h36, 'h37};
    int lvls[4] = '{'h0fff, 'h1000, 'h3fff, 'h4000};
    int srcs[3] = '{0, 2, 1};

    headphone_supply_pump_control dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .i_byteenable(4'hf), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .i_mclk_present(i_mclk_present),
        .i_loop_locked(i_loop_locked), .i_first_level(lvl1), .i_second_level(lvl2),
        .o_pump(o_pump));
    rail_load_model far (.i_clk(i_clk), .i_play_first(play1), .i_play_second(play2),
        .i_pump(o_pump), .o_first_level(lvl1), .o_second_level(lvl2), .o_ticks(ticks));

    // clock and watchdog
    initial begin
        i_clk = 0;
        forever #25 i_clk = ~i_clk;
    end
    initial begin
        repeat (30000) @(posedge i_clk);
        num_errors++;
        end_of_test();
    end
    // ----------------------------------------------------------------
    // reference model and shared tasks
    // ----------------------------------------------------------------
    function automatic logic run_ok();
        return en != 0 && (cs != 0 ? (i_loop_locked || fr != 0) : i_mclk_present);
    endfunction : run_ok
    function automatic point_t exp_point();
        int m;
        m = (src == 2) ? play2 : play1;
        if (!run_ok()) return PT_LOW;
        if (trk != 0) return m >= LVL_HIGH_TH ? PT_HIGH : m >= LVL_MID_TH ? PT_MID : PT_LOW;
        m = lv > rv ? lv : rv;
        return m >= VOL_HIGH_TH ? PT_HIGH : m >= VOL_MID_TH ? PT_MID : PT_LOW;
    endfunction : exp_point
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        i_address <= {idx, 2'b00};
        i_write <= wr;
        i_read <= !wr;
        i_writedata <= wd;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) check(1, 0);
        rd = o_readdata;
        i_write <= 0;
        i_read <= 0;
        @(posedge i_clk);
    endtask : bus
    task automatic wr_reg(input logic [7:0] idx, input logic [31:0] wd);
        case (idx)
            ENABLE_CTRL_IDX: en = wd[15];
            DISCHARGE_CTRL_IDX: dis = wd[15];
            TRACKING_CTRL_IDX: begin
                trk = wd[0];
                src = wd[9:8];
            end
            VOLUME_CTRL_IDX: begin
                lv = wd[5:0];
                rv = wd[13:8];
            end
            CLOCK_CTRL_IDX: begin
                cs = wd[0];
                fr = wd[1];
            end
            default: ;
        endcase
        bus(1, idx, wd);
    endtask : wr_reg
    // waits three pump ticks (or a bounded span when the clock is gone), then compares
    task automatic check_pump();
        int t0;
        t0 = ticks;
        for (int k = 0; k < 200 && ticks < t0 + 3; k++) @(posedge i_clk);
        repeat (2) @(posedge i_clk);
        check(o_pump.point, exp_point());
        check(o_pump.rail, run_ok() ? RAIL_RUN : dis != 0 ? RAIL_DISCH : RAIL_FLOAT);
    endtask : check_pump
    task automatic period(input int d);
        int n;
        n = 0;
        while (o_pump.pump_clk_en !== 1'b1 && n < 100) begin
            @(posedge i_clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pump.pump_clk_en !== 1'b1 && n < 100);
        check(n, d + 1);
    endtask : period
    task automatic end_of_test();
        if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(49542));
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1;
        @(posedge i_clk);
        bus(0, ENABLE_CTRL_IDX, 0);
        check(rd, 0);
        bus(0, DISCHARGE_CTRL_IDX, 0);
        check(rd, 32'h8000);
        bus(0, TRACKING_CTRL_IDX, 0);
        check(rd, 0);
        bus(0, 8'h3f, 0);
        check(rd, 0);
        check_pump();
        wr_reg(ENABLE_CTRL_IDX, 32'h8000);
        check_pump();
        bus(0, ENABLE_CTRL_IDX, 0);
        check(rd, 1 << ENABLE_BIT);
        // volume boundaries alternating right and left side, then random pairs
        for (int i = 0; i < 8; i++) begin
            wr_reg(VOLUME_CTRL_IDX, i < 4 ? (i[0] ? vols[i] : vols[i] << 8)
                : $urandom_range(0, 63) | ($urandom_range(0, 63) << 8));
            check_pump();
        end
        bus(0, VOLUME_CTRL_IDX, 0);
        check(rd, (rv << 8) | lv);
        // dynamic mode over source codes 0, 2 and 1 and every level boundary
        for (int s = 0; s < 3; s++) begin
            wr_reg(TRACKING_CTRL_IDX, (srcs[s] << 8) | 1);
            bus(0, TRACKING_CTRL_IDX, 0);
            check(rd, (src << 8) | trk);
            for (int i = 0; i < 4; i++) begin
                play1 <= lvls[i];
                play2 <= lvls[3 - i] ^ $urandom_range(0, 1);
                check_pump();
            end
        end
        wr_reg(TRACKING_CTRL_IDX, 0);
        check_pump();
        for (int d = 1; d < 7; d += 4) begin
            wr_reg(CLOCK_CTRL_IDX, d << 4);
            check_pump();
            period(d);
        end
        wr_reg(CLOCK_CTRL_IDX, 32'h11);
        check_pump();
        i_loop_locked <= 1;
        check_pump();
        i_loop_locked <= 0;
        wr_reg(CLOCK_CTRL_IDX, 32'h13);
        check_pump();
        wr_reg(CLOCK_CTRL_IDX, 32'h10);
        i_mclk_present <= 0;
        check_pump();
        i_mclk_present <= 1;
        wr_reg(DISCHARGE_CTRL_IDX, 0);
        wr_reg(ENABLE_CTRL_IDX, 0);
        check_pump();
        bus(0, PUMP_STATUS_IDX, 0);
        check(rd, (32'(PT_LOW) << 3) | 32'(RAIL_FLOAT));
        end_of_test();
    end
endmodule : headphone_supply_pump_control_tb
`default_nettype wire
